/* File: rtl/urf_rx_filter.sv */
/*
 Receive qualification for an asynchronous serial port: frame error flag,
 multiprocessor ninth-bit filter and address recognition, with an
 AXI4-Lite register slave and a receive FIFO.
 Assumes a bit engine upstream that delivers one finished frame as a
 one-cycle strobe with the data bits, ninth bit and stop bit sample.
 Limitation: bit timing, start detection and baud generation live upstream.
*/
// What this block does
// - Missing stop bit sets frame error flag
// - Control top bit: error flag or mode bit
// - Error flag cleared only by software
// - Nine-bit modes store ninth bit in flag
// - Nine-bit multiprocessor: accept only ninth bit one
// - Multiprocessor bit ignored in shift mode
// - Eight-bit multiprocessor: need valid stop bit
// - Nine-bit recognition: ninth one and address match
// - Eight-bit recognition: stop valid and address match
// - Given address: mask ones must match
// - Broadcast: address OR mask, zeros ignored
// - Reset clears address and mask to zero
// - Load only when done flag clear
// - Eight-bit mode stores stop bit as ninth
`timescale 1ns/10ps
`default_nettype none
module urf_rx_filter
    import urf_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic frame_valid,
    input wire urf_frame_t frame_in,
    output logic rx_done_flag,
    output logic byte_valid,
    input wire logic byte_ready,
    output urf_word_t byte_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Software-visible register copies
    logic [7:0] serial_control_reg_ff;
    logic [7:0] power_control_reg_ff;
    logic [7:0] slave_address_reg_ff;
    logic [7:0] slave_address_mask_reg_ff;
    logic frame_error_flag_ff;
    logic serial_mode_bit0_ff;
    logic [7:0] data_ff;
    // Write channel halves, held until both have arrived
    logic [7:0] wa_ff;
    logic [31:0] wd_ff;
    logic [3:0] ws_ff;
    logic aw_ff;
    logic w_ff;
    // Decode, qualification and buffer nets
    logic fifo_in_ready;
    logic fifo_out_valid;
    urf_word_t fifo_out;
    logic frame_error_select;
    logic multiprocessor_enable;
    urf_mode_t mode;
    logic [7:0] given_care;
    logic [7:0] bcast_care;
    logic addr_match;
    logic mp_ok;
    logic accept;
    logic ninth_val;
    logic wr_fire;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_view;

    // Field decode; mode bit 0 lives apart because the top bit is shared
    assign frame_error_select = power_control_reg_ff[PWR_FESEL];
    assign multiprocessor_enable = serial_control_reg_ff[CTL_MPEN];
    assign mode = urf_mode_t'({serial_mode_bit0_ff, serial_control_reg_ff[CTL_MODE1]});
    assign rx_done_flag = serial_control_reg_ff[CTL_RXDONE];

    ////////////////////////////////////////////////////////////////////////
    // Address recognition on the finished frame, no extra cycle
    // After reset both care masks are zero, so every byte matches and
    // software written for a plain port sees no filtering at all
    assign given_care = slave_address_mask_reg_ff;
    assign bcast_care = slave_address_reg_ff | slave_address_mask_reg_ff;
    always_comb begin
        // Given address or broadcast all-ones in cared bits
        addr_match = (((frame_in.data ^ slave_address_reg_ff) & given_care) == 8'h00)
            || ((~frame_in.data & bcast_care) == 8'h00);
    end

    // Qualification per mode; shift mode ignores the enable bit
    // The match is only consulted with the enable bit set
    always_comb begin
        case (mode)
            MODE_SHIFT: begin
                // No stop or ninth bit worth filtering on here
                mp_ok = 1'b1;
                ninth_val = frame_in.ninth;
            end
            MODE_8VAR: begin
                // Enabled: stop valid and address matched
                mp_ok = !multiprocessor_enable || (frame_in.stop_ok && addr_match);
                ninth_val = frame_in.stop_ok;
            end
            MODE_9FIX, MODE_9VAR: begin
                // Enabled: ninth bit one and address matched
                mp_ok = !multiprocessor_enable || (frame_in.ninth && addr_match);
                ninth_val = frame_in.ninth;
            end
            default: begin
                mp_ok = 1'b0;
                ninth_val = 1'b0;
            end
        endcase
    end

    // Trade-off: a full FIFO drops the frame rather than overwrite
    // its oldest byte, so software never loses bytes already counted
    // Lost unless the done flag is clear and the FIFO can take it
    assign accept = frame_valid && mp_ok && !rx_done_flag && fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    // Each ready drops while its own half is held or the answer waits, so a new write cannot overtake the answer
    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_ff && !s_axi_bvalid;
    assign wr_fire = aw_ff && w_ff && !s_axi_bvalid;
    assign ctrl_wr = wr_fire && (wa_ff[7:2] == OFF_CTRL[7:2]) && ws_ff[0];
    assign ctrl_wdata = wd_ff[7:0];

    // Channel capture; the answer waits until both halves are held
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            wa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                wa_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wd_ff <= s_axi_wdata;
                ws_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa_ff[7:2] <= OFF_STAT[7:2]) ? RESP_OK : RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Plain configuration registers
    // Limitation: only byte lane 0 is stored; upper lanes are ignored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            power_control_reg_ff <= 8'h00;
            slave_address_reg_ff <= ADDR_RST;
            slave_address_mask_reg_ff <= MASK_RST;
            serial_mode_bit0_ff <= 1'b0;
        end else if (clk_en && wr_fire && ws_ff[0]) begin
            case (wa_ff[7:2])
                OFF_PWR[7:2]: power_control_reg_ff <= wd_ff[7:0];
                OFF_ADDR[7:2]: slave_address_reg_ff <= wd_ff[7:0];
                OFF_MASK[7:2]: slave_address_mask_reg_ff <= wd_ff[7:0];
                OFF_CTRL[7:2]: begin
                    // Top bit lands on the mode bit only when selected
                    if (!frame_error_select) begin
                        serial_mode_bit0_ff <= wd_ff[CTL_TOP];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Frame error: set by hardware, cleared only by a zero write
    // A set in the same cycle as a clear wins, so no error is lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_error_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (frame_valid && !frame_in.stop_ok) begin
                frame_error_flag_ff <= 1'b1;
            end else if (ctrl_wr && frame_error_select && !ctrl_wdata[CTL_TOP]) begin
                frame_error_flag_ff <= 1'b0;
            end
        end
    end

    // Serial control low bits; an accepted frame beats a software clear
    // Bit 7 stays zero here; the visible top bit is chosen on read
    // between the error flag and the mode bit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_control_reg_ff <= CTRL_RST;
        end else if (clk_en) begin
            if (ctrl_wr) begin
                serial_control_reg_ff[6:0] <= ctrl_wdata[6:0];
            end
            if (accept) begin
                serial_control_reg_ff[CTL_RXDONE] <= 1'b1;
                serial_control_reg_ff[CTL_NINTH] <= ninth_val;
            end
            serial_control_reg_ff[CTL_TOP] <= 1'b0;
        end
    end

    // Received byte holding register
    // Software reads the newest accepted byte; the FIFO keeps its own copy
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_ff <= 8'h00;
        end else if (clk_en && accept) begin
            data_ff <= frame_in.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accepted bytes also stream out through the FIFO
    // Nine bits wide: the stored ninth bit travels with its byte
    urf_fifo #(.WIDTH(9), .DEPTH(DEPTH)) i_urf_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(accept),
        .in_ready(fifo_in_ready),
        .in_data({ninth_val, frame_in.data}),
        .out_valid(fifo_out_valid),
        .out_ready(byte_ready),
        .out_data(fifo_out)
    );
    // Stream side is a plain view of the FIFO head
    assign byte_valid = fifo_out_valid;
    assign byte_out = fifo_out;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    assign ctrl_view = {frame_error_select ? frame_error_flag_ff : serial_mode_bit0_ff,
                        serial_control_reg_ff[6:0]};
    // Registered answer; status packs the error flag with the FIFO not-empty and full flags

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OK;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OK;
                case (s_axi_araddr[7:2])
                    OFF_CTRL[7:2]: s_axi_rdata <= {24'h00_0000, ctrl_view};
                    OFF_PWR[7:2]: s_axi_rdata <= {24'h00_0000, power_control_reg_ff};
                    OFF_ADDR[7:2]: s_axi_rdata <= {24'h00_0000, slave_address_reg_ff};
                    OFF_MASK[7:2]: s_axi_rdata <= {24'h00_0000, slave_address_mask_reg_ff};
                    OFF_DATA[7:2]: s_axi_rdata <= {24'h00_0000, data_ff};
                    OFF_STAT[7:2]: s_axi_rdata <= {29'h0000_0000, frame_error_flag_ff,
                                                   fifo_out_valid, !fifo_in_ready};
                    default: begin
                        // Holes in the map answer with an error and zero data
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_ERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/urf_pkg.sv */
/*
 Package for the receive qualification block: register offsets, field
 positions, reset values, mode codes and the carried structs.
 Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
*/
package urf_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PWR = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    // Serial control fields
    localparam int CTL_RXDONE = 0;
    localparam int CTL_NINTH = 2;
    localparam int CTL_MPEN = 5;
    localparam int CTL_MODE1 = 6;
    localparam int CTL_TOP = 7;
    // Power control field
    localparam int PWR_FESEL = 6;
    // Reset values and bus response codes
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    // Clock and FIFO depth
    localparam int CLK_HZ = 10_000_000;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8VAR = 2'b01,
        MODE_9FIX = 2'b10,
        MODE_9VAR = 2'b11
    } urf_mode_t;

    // One finished frame from the bit engine
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop_ok;
    } urf_frame_t;

    // One accepted byte in the receive FIFO
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } urf_word_t;
endpackage

/* File: rtl/urf_fifo.sv */
/*
 Small flip-flop FIFO with valid and ready on both sides.
 Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/10ps
`default_nettype none
module urf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    // Handshakes; full and empty come straight from the count
    assign in_ready = (cnt_ff < (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;
    assign out_data = mem_ff[rd_ff];

    ////////////////////////////////////////////////////////////////////////
    // Storage and pointers
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/urf_rx_filter_properties.sv */
/*
 Port checker for the receive filter.
 Assumes a bind onto urf_rx_filter, one clock and clk_en mostly high.
*/
`timescale 1ns/10ps
`default_nettype none
module urf_rx_filter_checker
    import urf_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic frame_valid,
    input wire logic rx_done_flag,
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire urf_word_t byte_out,
    input wire logic s_axi_awready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Receive flag and buffer
    property p_done_src; $rose(rx_done_flag) |-> $past(frame_valid) && $past(clk_en); endproperty
    a_done_src: assert property (p_done_src) else $error("done rose without frame");
    property p_done_push; $rose(rx_done_flag) |-> byte_valid; endproperty
    a_done_push: assert property (p_done_push) else $error("accepted byte not buffered");
    // Only a register write may drop the flag, never a frame
    property p_done_clr; $fell(rx_done_flag) |-> s_axi_bvalid || $past(s_axi_wvalid); endproperty
    a_done_clr: assert property (p_done_clr) else $error("done fell without write");
    property p_head; byte_valid && !(byte_ready && clk_en) |=> byte_valid && $stable(byte_out); endproperty
    a_head: assert property (p_head) else $error("buffer head moved while stalled");
    property p_freeze; !clk_en |=> $stable(rx_done_flag) && $stable(byte_valid); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
    ////////////////////////////////////////
    // Register bus timing
    property p_bresp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en |-> ##2 s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write answer late");
    property p_rresp; s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid; endproperty
    a_rresp: assert property (p_rresp) else $error("read answer late");
    property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wbusy: assert property (p_wbusy) else $error("write taken during answer");
    property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rbusy: assert property (p_rbusy) else $error("read taken during answer");
    property p_rhigh; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
    a_rhigh: assert property (p_rhigh) else $error("upper read bits set");
    property p_bdone; s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid; endproperty
    a_bdone: assert property (p_bdone) else $error("write answer repeated");
    c_accept: cover property ($rose(rx_done_flag));
    c_pop: cover property (byte_valid && byte_ready);
    c_read: cover property (s_axi_rvalid);
endmodule
bind urf_rx_filter urf_rx_filter_checker i_chk (.clock, .sys_rst, .clk_en, .frame_valid, .rx_done_flag,
    .byte_valid, .byte_ready, .byte_out, .s_axi_awready, .s_axi_awvalid, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata);
`default_nettype wire

/* File: bench/urf_serial_node.sv */
/*
 Remote serial node: hands finished frames to the filter.
 Assumes the caller sits in clock-edge context.
*/
`timescale 1ns/10ps
`default_nettype none
module urf_serial_node
    import urf_pkg::*;
(
    input wire logic clock,
    output var logic frame_valid,
    output var urf_frame_t frame_in
);
    // Idle at time zero
    initial begin
        frame_valid = 1'b0;
        frame_in = '0;
    end
    // One strobe; payload inverted after it so stale data cannot pass
    task automatic send(input logic [7:0] d, input logic n, input logic s);
        @(posedge clock);
        frame_valid <= 1'b1;
        frame_in <= '{data: d, ninth: n, stop_ok: s};
        @(posedge clock);
        frame_valid <= 1'b0;
        frame_in <= ~frame_in;
    endtask
endmodule
`default_nettype wire

/* File: bench/urf_rx_filter_tb.sv */
/*
 Self-checking bench for the receive filter.
 Assumes the serial node model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module urf_rx_filter_tb
    import urf_pkg::*;
;
    logic clock, sys_rst, clk_en, byte_ready, byte_valid, rx_done_flag, frame_valid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ctrl;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    urf_frame_t frame_in;
    urf_word_t byte_out;
    int failures, tests_run, cycles;
    urf_rx_filter i_urf_rx_filter (.clock, .sys_rst, .clk_en, .frame_valid, .frame_in, .rx_done_flag,
        .byte_valid, .byte_ready, .byte_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    urf_serial_node i_urf_serial_node (.clock, .frame_valid, .frame_in);
    ////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_sim;
        end
    end
    task automatic end_sim;
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////
    // Bus master: each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rsp = s_axi_rresp;
        chk(s_axi_rdata, exp);
    endtask
    // One frame; expected ninth flag is the stop bit in mode 1, else the ninth bit
    task automatic frame(input logic [7:0] d, input logic n, input logic s, input logic acc);
        i_urf_serial_node.send(d, n, s);
        @(negedge clock);
        chk({31'h0, rx_done_flag}, {31'h0, acc});
        if (acc) rchk(OFF_DATA, {24'h0, d});
        if (acc && ctrl[7:6] != 2'b00) rchk(OFF_CTRL, {24'h0, ctrl[7:3], ctrl[7] ? n : s, ctrl[1], 1'b1});
        wr(OFF_CTRL, {24'h0, ctrl});
    endtask
    ////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rchk(OFF_ADDR, 32'h0);
        rchk(OFF_MASK, 32'h0);
        rchk(8'h18, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_ERR});
        ctrl = 8'h20;
        wr(OFF_CTRL, {24'h0, ctrl});
        frame(8'h5A, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_9bit;
        ctrl = 8'hA0;
        wr(OFF_CTRL, {24'h0, ctrl});
        frame(8'h37, 1'b1, 1'b1, 1'b1);
        wr(OFF_ADDR, 32'h0000_00C0);
        wr(OFF_MASK, 32'h0000_00FD);
        frame(8'hC2, 1'b0, 1'b1, 1'b0);
        frame(8'hC1, 1'b1, 1'b1, 1'b0);
        frame(8'hC2, 1'b1, 1'b1, 1'b1);
        frame(8'hFF, 1'b1, 1'b1, 1'b1);
        frame(8'hF5, 1'b1, 1'b1, 1'b0);
        i_urf_serial_node.send(8'hC0, 1'b1, 1'b1);
        i_urf_serial_node.send(8'hFF, 1'b1, 1'b1);
        rchk(OFF_DATA, 32'h0000_00C0);
        ctrl = 8'hC0;
        wr(OFF_CTRL, {24'h0, ctrl});
        frame(8'h11, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_8bit;
        ctrl = 8'h60;
        wr(OFF_CTRL, {24'h0, ctrl});
        wr(OFF_CTRL, {24'h0, ctrl});
        frame(8'hC2, 1'b0, 1'b0, 1'b0);
        rchk(OFF_STAT, 32'h0000_0004);
        frame(8'hC1, 1'b0, 1'b1, 1'b0);
        frame(8'hC0, 1'b0, 1'b1, 1'b1);
        rchk(OFF_CTRL, 32'h0000_0060);
        wr(OFF_PWR, 32'h0000_0040);
        rchk(OFF_CTRL, 32'h0000_00E0);
        repeat (5) @(posedge clock);
        rchk(OFF_CTRL, 32'h0000_00E0);
        wr(OFF_CTRL, 32'h0000_0060);
        rchk(OFF_CTRL, 32'h0000_0060);
        rchk(OFF_STAT, 32'h0);
        i_urf_serial_node.send(8'hC0, 1'b0, 1'b0);
        rchk(OFF_STAT, 32'h0000_0004);
        rchk(OFF_CTRL, 32'h0000_00E0);
        wr(OFF_CTRL, 32'h0000_0060);
        rchk(OFF_STAT, 32'h0);
        wr(OFF_PWR, 32'h0);
    endtask
    // Fill with the consumer stalled, then drain in order
    task automatic t_fifo;
        ctrl = 8'h00;
        wr(OFF_CTRL, 32'h0);
        byte_ready <= 1'b0;
        for (int i = 0; i <= FIFO_DEPTH; i++) frame(i[7:0], 1'b0, 1'b1, i < FIFO_DEPTH);
        rchk(OFF_STAT, 32'h0000_0003);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            @(posedge clock);
            byte_ready <= 1'b1;
            @(negedge clock);
            chk({23'h0, byte_out}, {23'h0, 1'b0, i[7:0]});
            @(posedge clock);
            byte_ready <= 1'b0;
        end
        rchk(OFF_STAT, 32'h0);
        // A frame offered with the clock enable low must leave no trace
        @(posedge clock);
        clk_en <= 1'b0;
        i_urf_serial_node.send(8'h33, 1'b0, 1'b1);
        @(negedge clock);
        chk({31'h0, rx_done_flag}, 32'h0);
        @(posedge clock);
        clk_en <= 1'b1;
        rchk(OFF_DATA, 32'h0000_000F);
        rchk(OFF_STAT, 32'h0);
        wr(OFF_ADDR, 32'h0000_00AA);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        rchk(OFF_ADDR, 32'h0);
    endtask
    initial begin
        {sys_rst, clk_en, byte_ready, s_axi_wstrb} = 7'h7F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, tests_run, cycles} = '0;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset;
        t_9bit;
        t_8bit;
        t_fifo;
        end_sim;
    end
endmodule
`default_nettype wire
